// ### astx_top.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Idle line rests at mark
// - Equal bits hold level, no return
// - Start, eight or nine data, stop
// - Start is space, stop is mark
// - Every bit lasts one baud period
// - Dedicated 8/16-bit baud divider
// - LSb first, shared format and rate
// - No hardware parity; ninth bit given
// - Shift register hidden, loads from buffer
// - Port enable makes pin an output
// - Buffer write starts; moves if empty
// - Queued char moves after stop bit
// - Polarity bit inverts idle and data
// - Polarity used in async only
// - Flag set while enabled, buffer empty
// - Enabling transmitter sets the flag
// - Flag valid second cycle after write
// - Flag read-only
// - Irq enable only gates the request
module astx_top
	import astx_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic [2:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// Serial pin
	output logic o_tx,
	output logic o_tx_oe_n,
	// Flag and gated request
	output logic o_tx_flag,
	output logic o_tx_irq
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [15:0] baud;
		logic [8:0] hold;
		logic full;
		logic [8:0] shreg;
		logic [3:0] bitn;
		logic [3:0] nbits;
		astx_state_type state;
		logic tx;
		logic oe_n;
		logic flag;
		logic [1:0] fdly;
		logic [15:0] rdata;
	} astx_top_type;
	astx_top_type st_r;
	astx_top_type st_nxt;
	logic rst_n;
	logic tick;
	logic restart;
	logic line;
	logic async_on;

	// Line level with optional inversion
	function automatic logic drive(input logic lvl, input logic inv);
		drive = lvl ^ inv;
	endfunction

	astx_sync u_sync
	(
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.o_rst_n(rst_n)
	);

	// Divider restarts when a frame begins so the start bit is whole
	assign restart = (st_r.state == ASTX_IDLE);
	astx_baud u_baud
	(
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_div(st_r.baud),
		.i_b16(st_r.ctrl[CTRL_B16]),
		.i_restart(restart),
		.o_tick(tick)
	);

	assign async_on = st_r.ctrl[CTRL_TRANSMIT_ENABLE] & st_r.ctrl[CTRL_SERIAL_PORT_ENABLE] & ~st_r.ctrl[CTRL_SYNC];

	// Main next-state logic
	always_comb
	begin
		st_nxt = st_r;
		line = 1'b1;
		// Register writes; shift register has no address
		if (i_wr)
		begin
			unique case (i_addr)
				ADDR_CTRL: st_nxt.ctrl = i_wdata[7:0];
				ADDR_BAUD: st_nxt.baud = i_wdata;
				ADDR_DATA:
				begin
					st_nxt.hold = i_wdata[8:0];
					st_nxt.full = 1'b1;
					st_nxt.fdly = FLAG_DELAY;
				end
				default: st_nxt.ctrl = st_r.ctrl; // Status read-only
			endcase
		end
		// Frame sequencing
		unique case (st_r.state)
			ASTX_IDLE:
			begin
				line = 1'b1;
				if (st_r.full && async_on)
				begin
					st_nxt.shreg = st_r.hold;
					st_nxt.full = 1'b0;
					st_nxt.nbits = st_r.ctrl[CTRL_NINE] ? BITS_NINE : BITS_EIGHT;
					st_nxt.state = ASTX_START;
				end
			end
			ASTX_START:
			begin
				line = 1'b0;
				if (tick)
				begin
					st_nxt.bitn = 4'h0;
					st_nxt.state = ASTX_DATA;
				end
			end
			ASTX_DATA:
			begin
				line = st_r.shreg[0];
				if (tick)
				begin
					st_nxt.shreg = {1'b0, st_r.shreg[8:1]};
					st_nxt.bitn = st_r.bitn + 4'h1;
					if (st_r.bitn + 4'h1 == st_r.nbits)
						st_nxt.state = ASTX_STOP;
				end
			end
			ASTX_STOP:
			begin
				line = 1'b1;
				if (tick)
				begin
					if (st_r.full && async_on)
					begin
						// Queued character moves in at once, start follows
						st_nxt.shreg = st_r.hold;
						st_nxt.full = 1'b0;
						st_nxt.nbits = st_r.ctrl[CTRL_NINE] ? BITS_NINE : BITS_EIGHT;
						st_nxt.state = ASTX_START;
					end
					else
						st_nxt.state = ASTX_IDLE;
				end
			end
		endcase
		// A write in the same cycle as the hand-off must survive
		if (i_wr && i_addr == ADDR_DATA)
			st_nxt.full = 1'b1;
		// Inversion only meaningful in async mode
		st_nxt.tx = drive(line, st_r.ctrl[CTRL_POL] & ~st_r.ctrl[CTRL_SYNC]);
		st_nxt.oe_n = ~st_r.ctrl[CTRL_SERIAL_PORT_ENABLE];
		// Flag lags a buffer write by two cycles
		if (st_r.fdly != 2'h0)
			st_nxt.fdly = st_r.fdly - 2'h1;
		// A fresh data write restarts the hold-off and freezes the flag
		if (i_wr && i_addr == ADDR_DATA)
			st_nxt.fdly = FLAG_DELAY;
		else if (st_r.fdly == 2'h0 || st_r.fdly == 2'h1)
			st_nxt.flag = st_r.ctrl[CTRL_TRANSMIT_ENABLE] & ~st_nxt.full;
		// Read data one cycle after the strobe
		st_nxt.rdata = 16'h0000;
		if (i_rd)
		begin
			unique case (i_addr)
				ADDR_CTRL: st_nxt.rdata = {8'h00, st_r.ctrl};
				ADDR_BAUD: st_nxt.rdata = st_r.baud;
				ADDR_DATA: st_nxt.rdata = {7'h00, st_r.hold};
				ADDR_STAT: st_nxt.rdata = {13'h0000, st_r.full, st_r.state != ASTX_IDLE, st_r.flag};
				default: st_nxt.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r <= '0;
			st_r.ctrl <= CTRL_RESET;
			st_r.baud <= BAUD_RESET;
			st_r.tx <= 1'b1;
			st_r.oe_n <= 1'b1;
			st_r.state <= ASTX_IDLE;
		end
		else
			st_r <= st_nxt;
	end

	assign o_rdata = st_r.rdata;
	assign o_tx = st_r.tx;
	assign o_tx_oe_n = st_r.oe_n;
	assign o_tx_flag = st_r.flag;
	assign o_tx_irq = st_r.flag & st_r.ctrl[CTRL_IE];

	// Checks
	sequence s_idle_line;
		st_r.state == ASTX_IDLE;
	endsequence
	a_idle_mark: assert property (@(posedge i_clk) disable iff (!rst_n)
		s_idle_line ##1 (st_r.state == ASTX_IDLE) |-> o_tx == st_r.ctrl[CTRL_POL] ^ 1'b1 || $changed(st_r.ctrl))
		else $error("idle line not at mark");
	a_start_space: assert property (@(posedge i_clk) disable iff (!rst_n)
		(st_r.state == ASTX_IDLE) ##1 (st_r.state == ASTX_START) |-> ##1 o_tx == st_r.ctrl[CTRL_POL])
		else $error("start bit not space");
	a_flag_ro: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_wr && i_addr == ADDR_STAT && st_r.fdly == 2'h0 && st_r.full == st_nxt.full
		&& !$changed(st_r.ctrl)) |=> o_tx_flag == $past(o_tx_flag) || st_r.fdly != 2'h0)
		else $error("flag changed by write");
	a_flag_delay: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_wr && i_addr == ADDR_DATA) |=> o_tx_flag == $past(o_tx_flag))
		else $error("flag changed at once");
	a_irq_gate: assert property (@(posedge i_clk) disable iff (!rst_n)
		o_tx_irq |-> o_tx_flag && st_r.ctrl[CTRL_IE])
		else $error("irq without flag");
	a_oe_follow: assert property (@(posedge i_clk) disable iff (!rst_n)
		st_r.ctrl[CTRL_SERIAL_PORT_ENABLE] |=> !o_tx_oe_n)
		else $error("pin not driven");
	a_stop_len: assert property (@(posedge i_clk) disable iff (!rst_n)
		(st_r.state == ASTX_STOP && !tick) |=> st_r.state == ASTX_STOP)
		else $error("stop bit cut short");
	a_bit_count: assert property (@(posedge i_clk) disable iff (!rst_n)
		(st_r.state == ASTX_DATA) |-> st_r.bitn < st_r.nbits)
		else $error("too many data bits");
endmodule
`default_nettype wire

// ### astx_pkg.sv
package astx_pkg;
	// Register indices on the plain port
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_BAUD = 3'h1;
	localparam logic [2:0] ADDR_DATA = 3'h2;
	localparam logic [2:0] ADDR_STAT = 3'h3;
	// Control register fields
	localparam int CTRL_TRANSMIT_ENABLE = 0;
	localparam int CTRL_SYNC = 1;
	localparam int CTRL_SERIAL_PORT_ENABLE = 2;
	localparam int CTRL_POL = 3;
	localparam int CTRL_NINE = 4;
	localparam int CTRL_B16 = 5;
	localparam int CTRL_IE = 6;
	localparam int CTRL_D8 = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] BAUD_RESET = 16'h0000;
	// Status register fields
	localparam int STAT_FLAG = 0;
	localparam int STAT_BUSY = 1;
	localparam int STAT_FULL = 2;
	// Frame bit counts
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [3:0] BITS_NINE = 4'h9;
	// Write to flag valid delay in cycles
	localparam logic [1:0] FLAG_DELAY = 2'h2;
	typedef enum logic [1:0] {ASTX_IDLE, ASTX_START, ASTX_DATA, ASTX_STOP} astx_state_type;
endpackage

// ### astx_sync.sv
`timescale 1ns/100ps
`default_nettype none
module astx_sync
(
	// Clock and raw reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Released reset
	output logic o_rst_n
);
	typedef struct packed {
		logic s1;
		logic s2;
	} astx_sync_type;
	astx_sync_type st_r;
	astx_sync_type st_nxt;

	// Second stage only reads the first
	always_comb
	begin
		st_nxt.s1 = 1'b1;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign o_rst_n = st_r.s2;
endmodule
`default_nettype wire

// ### astx_baud.sv
`timescale 1ns/100ps
`default_nettype none
module astx_baud
	import astx_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Divider setup
	input wire logic [15:0] i_div,
	input wire logic i_b16,
	input wire logic i_restart,
	// Bit period tick
	output logic o_tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} astx_baud_type;
	astx_baud_type st_r;
	astx_baud_type st_nxt;
	logic [15:0] limit;

	// Eight bit mode only looks at the low byte
	assign limit = i_b16 ? i_div : {8'h00, i_div[7:0]};

	// Period is limit+1 cycles; restart aligns to a fresh bit
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		// Restart preloads one so the registered tick still gives limit+1 cycles
		if (i_restart)
			st_nxt.cnt = 16'h0001;
		else if (st_r.cnt >= limit)
		begin
			st_nxt.cnt = 16'h0000;
			st_nxt.tick = 1'b1;
		end
		else
			st_nxt.cnt = st_r.cnt + 16'h0001;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign o_tick = st_r.tick;
endmodule
`default_nettype wire

// ### astx_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
// Far-end receiver, resyncs on every start edge
module astx_rx_model
(
	// Line and format
	input wire logic i_clk,
	input wire logic i_line,
	input wire logic i_en,
	input wire logic i_inv,
	input wire logic i_nine,
	input wire logic [15:0] i_per,
	// Received character
	output logic o_got,
	output logic [8:0] o_data,
	output logic o_ok
);
	int k;
	// Mid-bit sampling, so a wrong bit length drifts into a bad sample
	initial
	begin
		o_got = 0;
		o_data = 0;
		o_ok = 0;
		forever
		begin
			@(posedge i_clk);
			o_got = 0;
			if (i_en && (i_line ^ i_inv) === 1'b0)
			begin
				repeat (i_per / 2) @(posedge i_clk);
				o_ok = (i_line ^ i_inv) === 1'b0;
				o_data = 0;
				for (k = 0; k < 8 + i_nine; k++)
				begin
					repeat (i_per) @(posedge i_clk);
					o_data[k] = i_line ^ i_inv;
				end
				repeat (i_per) @(posedge i_clk);
				o_ok = o_ok && (i_line ^ i_inv) === 1'b1;
				o_got = 1;
			end
		end
	end
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import astx_pkg::*;
	logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0;
	logic [2:0] i_addr = 0;
	logic [15:0] i_wdata = 0, o_rdata, rv, per = 16'h0004;
	logic o_tx, o_tx_oe_n, o_tx_flag, o_tx_irq, rx_got, rx_ok, en = 0, inv = 0, nine = 0;
	logic [8:0] rx_data;
	logic [7:0] ctl;
	int err_total = 0, total_checks = 0, q[$], c, n, d;
	astx_top i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .o_tx(o_tx), .o_tx_oe_n(o_tx_oe_n), .o_tx_flag(o_tx_flag),
		.o_tx_irq(o_tx_irq));
	astx_rx_model i_rx (.i_clk(i_clk), .i_line(o_tx), .i_en(en), .i_inv(inv), .i_nine(nine), .i_per(per),
		.o_got(rx_got), .o_data(rx_data), .o_ok(rx_ok));
	// Clock
	initial
		forever #2.5 i_clk = ~i_clk;
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e)
		begin
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
			err_total++;
		end
	endtask
	task automatic finish_test;
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Strobe stays up so writes can follow back to back
	task automatic wr(input logic [2:0] a, input logic [15:0] w);
		i_addr <= a;
		i_wdata <= w;
		i_wr <= 1'b1;
		@(posedge i_clk);
	endtask
	task automatic rel;
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] r);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 r = o_rdata;
		@(posedge i_clk);
	endtask
	// Bounded wait for the receiver to empty the expected queue
	task automatic drain;
		for (n = 0; n < 8000 && q.size() > 0; n++)
			@(posedge i_clk);
		if (q.size() > 0)
		begin
			err_total++;
			finish_test;
		end
	endtask
	// Each received character against the oldest expected one
	always @(posedge rx_got)
	begin
		chk({7'h0, rx_data}, 16'(q.pop_front()));
		chk({15'h0, rx_ok}, 16'h0001);
	end
	initial
	begin
		void'($urandom(42020));
		repeat (20) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		rd(ADDR_CTRL, rv);
		chk(rv, {8'h0, CTRL_RESET});
		rd(ADDR_BAUD, rv);
		chk(rv, BAUD_RESET);
		// Unmapped indices read zero
		for (c = 4; c < 8; c++)
		begin
			rd(3'(c), rv);
			chk(rv, 16'h0000);
		end
		chk({15'h0, o_tx}, 16'h0001);
		chk({15'h0, o_tx_oe_n}, 16'h0001);
		// Every mix of width, polarity and divider size
		for (c = 0; c < 8; c++)
		begin
			en <= 1'b0;
			wr(ADDR_CTRL, 16'h0004);
			rel;
			repeat (4) @(posedge i_clk);
			chk({15'h0, o_tx_flag}, 16'h0000);
			chk({15'h0, o_tx_oe_n}, 16'h0000);
			d = c[2] ? 256 + $urandom % 4 : 3 + $urandom % 4;
			wr(ADDR_BAUD, 16'(d) | (c[2] ? 16'h0 : 16'($urandom) & 16'hff00));
			per <= 16'(d + 1);
			ctl = 8'(1 << CTRL_TRANSMIT_ENABLE | 1 << CTRL_SERIAL_PORT_ENABLE | c[0] << CTRL_NINE | c[1] << CTRL_POL
				| c[2] << CTRL_B16 | c[0] << CTRL_IE);
			wr(ADDR_CTRL, {8'h0, ctl});
			rel;
			repeat (4) @(posedge i_clk);
			chk({15'h0, o_tx_flag}, 16'h0001);
			chk({15'h0, o_tx_irq}, {15'h0, ctl[CTRL_IE]});
			chk({15'h0, o_tx}, {15'h0, ~ctl[CTRL_POL]});
			wr(ADDR_STAT, 16'h0000);
			rel;
			rd(ADDR_STAT, rv);
			chk(rv & 16'h0001, 16'h0001);
			rd(ADDR_CTRL, rv);
			chk(rv & 16'h007f, {8'h0, ctl});
			inv <= ctl[CTRL_POL];
			nine <= c[0];
			en <= 1'b1;
			// Second character queues behind the first
			for (n = 0; n < 2; n++)
			begin
				d = $urandom % 512;
				q.push_back(c[0] ? d : d % 256);
				wr(ADDR_DATA, 16'(d));
			end
			wr(ADDR_CTRL, {8'h0, ctl & ~8'(1 << CTRL_IE)});
			rel;
			repeat (2) @(posedge i_clk);
			chk({15'h0, o_tx_flag}, 16'h0000);
			chk({15'h0, o_tx_irq}, 16'h0000);
			drain;
			repeat (per + 4) @(posedge i_clk);
			chk({15'h0, o_tx_flag}, 16'h0001);
			chk({15'h0, o_tx}, {15'h0, ~ctl[CTRL_POL]});
		end
		finish_test;
	end
endmodule
`default_nettype wire
